//--- testbench/ffcr_ctrl_model.sv
/* ffcr_ctrl_model: behavioural timing controller driving the three gate pins.
   assumes the bench clock; a request is held until busy rises. */
`timescale 1ns/1ns
module ffcr_ctrl_model (
    input  wire logic       clk,
    input  wire logic       req,
    input  wire logic       xfer,
    input  wire logic [8:0] nshift,
    input  wire logic       expose,
    output logic            busy,
    output logic            image_area_transfer_clock,
    output logic            serial_register_shift_clock,
    output logic            antiblooming_gate_clock
);
    logic [2:0] gates = 3'h0;
    initial busy = 1'b0;
    assign {image_area_transfer_clock, serial_register_shift_clock, antiblooming_gate_clock} = gates;
    // 3 cycles per level: the sensor synchroniser needs that long
    task automatic pulse(input int b);
        #1 gates[b] = 1'b1;
        repeat (3) @(posedge clk);
        #1 gates[b] = 1'b0;
        repeat (3) @(posedge clk);
    endtask
    always begin
        @(posedge clk);
        if (req) begin
            busy = 1'b1; // antiblooming gate left idle while reading
            if (xfer) pulse(2); // one line a pulse
            repeat (nshift) pulse(1); // nshift shifts; 210 drains every cell
            #1 busy = 1'b0;
        end else if (expose) pulse(0); // burst in each blanking gap
    end
endmodule // ffcr_ctrl_model

//--- testbench/full_frame_ccd_readout_timing_bench.sv
/* full_frame_ccd_readout_timing_bench: directed scenarios for ffcr_sensor.
   assumes ffcr_pkg and ffcr_ctrl_model are compiled first. */
`timescale 1ns/1ns
module full_frame_ccd_readout_timing_bench;
    logic                clk = 1'b0, rst_b = 1'b0, req = 1'b0, xfer = 1'b0, expose = 1'b0, pix_ready = 1'b0;
    logic                busy, image_area_transfer_clock, serial_register_shift_clock, antiblooming_gate_clock;
    logic                pix_valid, shift_stall;
    logic [8:0]          nshift = 9'h000;
    logic [11:0]         light_level = 12'h000;
    logic [7:0]          lines_left;
    ffcr_pkg::ffcr_pix_s pix;
    ffcr_pkg::ffcr_pix_s got[$];
    int                  fail_count = 0, n_checks = 0, stalls = 0;
    always #5 clk = ~clk;
    ffcr_ctrl_model ctrl (.clk, .req, .xfer, .nshift, .expose, .busy, .image_area_transfer_clock,
        .serial_register_shift_clock, .antiblooming_gate_clock);
    ffcr_sensor uut (.clk, .rst_b, .image_area_transfer_clock, .serial_register_shift_clock,
        .antiblooming_gate_clock, .light_level, .pix_valid, .pix_ready, .pix, .shift_stall, .lines_left);
    always @(posedge clk) begin
        if (pix_valid === 1'b1 && pix_ready === 1'b1) got.push_back(pix);
        if (shift_stall === 1'b1) stalls++;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task finish_test;
        if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task run(input logic x, input logic [8:0] n);
        int k;
        @(posedge clk);
        #1 req = 1'b1;
        xfer = x;
        nshift = n;
        for (k = 0; k < 20 && busy !== 1'b1; k++) @(posedge clk) #1;
        req = 1'b0;
        for (k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clk) #1;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task check_line(input logic [11:0] img, input logic [7:0] ln);
        int i;
        chk(got.size(), 210);
        for (i = 0; i < got.size(); i++) begin
            chk(got[i].kind, i < 6 ? ffcr_pkg::FFCR_KIND_DUMMY : i < 198 ? ffcr_pkg::FFCR_KIND_IMAGE
                : ffcr_pkg::FFCR_KIND_DARK);
            if (i >= 198) chk(got[i].charge, 0);
            if (i >= 6 && i < 198) chk(got[i].charge, img);
            chk(got[i].line, ln);
        end
    endtask
    task t_line;
        expose = 1'b1;
        light_level = 12'h5a5;
        repeat (40) @(posedge clk);
        #1 expose = 1'b0;
        light_level = 12'h000;
        pix_ready = 1'b1;
        run(1'b1, 9'd210);
        chk(lines_left, 164);
        check_line(12'h5a5, 8'h00);
    endtask
    task t_clear;
        int i;
        got.delete();
        run(1'b1, 9'd0);
        chk(pix_valid, 0);
        run(1'b1, 9'd210);
        check_line(12'h5a5, 8'h02);
        chk(lines_left, 162);
        for (i = 0; i < 162; i++) run(1'b1, 9'd0);
        chk(lines_left, 0);
        run(1'b1, 9'd0);
        chk(lines_left, 164);
    endtask
    task t_fifo;
        rst_b = 1'b0;
        repeat (3) @(posedge clk);
        #1 rst_b = 1'b1;
        got.delete();
        stalls = 0;
        pix_ready = 1'b0;
        run(1'b1, 9'd9);
        chk(stalls, 1); // ninth shift finds the buffer full
        chk(pix_valid, 1);
        pix_ready = 1'b1;
        repeat (12) @(posedge clk);
        #1 chk(got.size(), ffcr_pkg::FIFO_DEPTH);
        chk(pix_valid, 0);
    endtask
    initial begin
        #200000 fail_count++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 rst_b = 1'b1;
        chk(lines_left, ffcr_pkg::LINES);
        chk(pix_valid, 0);
        t_line();
        t_clear();
        t_fifo();
        finish_test();
    end
endmodule // full_frame_ccd_readout_timing_bench

//--- verilog/ffcr_pkg.sv
/*
 * ffcr_pkg: constants and carrier types for the full-frame sensor readout model.
 * assumes a single 100 MHz clock domain; gate clocks arrive as pins from the timing controller.
 */
package ffcr_pkg;
    localparam int LINES          = 165;
    localparam int IMG_PIX        = 192;
    localparam int DARK_PIX       = 12;
    localparam int DUMMY_CELLS    = 6;
    localparam int CLEARED_CELLS  = IMG_PIX + DARK_PIX;
    localparam int SREG_CELLS     = DUMMY_CELLS + CLEARED_CELLS;
    localparam int PIX_W          = 12;
    localparam int FIFO_DEPTH     = 8;
    localparam int SYNC_STAGES    = 2;
    localparam logic [7:0] LINE_RST = 8'h00;

    typedef enum logic [1:0] {
        FFCR_KIND_DUMMY,
        FFCR_KIND_IMAGE,
        FFCR_KIND_DARK
    } ffcr_kind_e;

    typedef struct packed {
        logic [PIX_W-1:0] charge;
        ffcr_kind_e       kind;
        logic [7:0]       line;
    } ffcr_pix_s;
endpackage

//--- verilog/ffcr_sensor.sv
/*
 * ffcr_fifo and ffcr_sensor: behavioural readout of a full-frame sensor.
 * gate clocks are asynchronous pins, synchronised before use; light arrives as one charge level
 * shared by every image pixel; shifted packets leave through an 8-word fifo with valid/ready.
 */
`timescale 1ns/1ns
module ffcr_fifo #(
    parameter int W = 24,
    parameter int D = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0]   cnt, next_cnt;
    logic          push, pop;

    assign in_ready  = (cnt != (AW+1)'(D));
    assign out_valid = (cnt != '0);
    assign out_data  = mem[rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wp  = push ? ((wp == AW'(D-1)) ? '0 : wp + 1'b1) : wp;
        next_rp  = pop ? ((rp == AW'(D-1)) ? '0 : rp + 1'b1) : rp;
        next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            wp  <= next_wp;
            rp  <= next_rp;
            cnt <= next_cnt;
        end
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_b) cnt <= (AW+1)'(D))
        else $error("fifo count above depth");
endmodule // ffcr_fifo

`timescale 1ns/1ns
// Contract
// - image area is 165 lines of 192 light pixels
// - 12 shielded dark pixels follow each line's image pixels, read in sequence
// - each image transfer pulse moves exactly one line into serial register; with no lines left the code loads empty image cells and reloads 164
// - each image transfer pulse clears the 192 image and 12 dark cells
// - the six front dummy cells are not cleared by image transfer
module ffcr_sensor #(
    parameter int PIX_W = ffcr_pkg::PIX_W,
    parameter int DEPTH = ffcr_pkg::FIFO_DEPTH
) (
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    input  wire logic                          image_area_transfer_clock,
    input  wire logic                          serial_register_shift_clock,
    input  wire logic                          antiblooming_gate_clock,
    input  wire logic [PIX_W-1:0]              light_level,
    output logic                               pix_valid,
    input  wire logic                          pix_ready,
    output ffcr_pkg::ffcr_pix_s                pix,
    output logic                               shift_stall,
    output logic [7:0]                         lines_left
);
    localparam int SC = ffcr_pkg::SREG_CELLS;
    localparam int DC = ffcr_pkg::DUMMY_CELLS;

    logic [2:0] ia_s, sr_s, ab_s;
    logic       ia_rise, sr_rise;
    logic [PIX_W-1:0] sreg [SC];
    logic [PIX_W-1:0] next_sreg [SC];
    logic [PIX_W-1:0] well, next_well;
    logic [7:0] line, next_line, next_lines_left;
    logic [7:0] out_idx, next_out_idx;
    logic       f_in_ready;
    ffcr_pkg::ffcr_pix_s pkt;

    function automatic ffcr_pkg::ffcr_kind_e kind_of(input logic [7:0] idx);
        if (idx < 8'(DC)) begin
            return ffcr_pkg::FFCR_KIND_DUMMY;
        end else if (idx < 8'(DC + ffcr_pkg::IMG_PIX)) begin
            return ffcr_pkg::FFCR_KIND_IMAGE;
        end
        return ffcr_pkg::FFCR_KIND_DARK;
    endfunction

    // bit0 first stage only feeds bit1; edge detect uses bits 1 and 2
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ia_s <= '0;
            sr_s <= '0;
            ab_s <= '0;
        end else begin
            ia_s <= {ia_s[1:0], image_area_transfer_clock};
            sr_s <= {sr_s[1:0], serial_register_shift_clock};
            ab_s <= {ab_s[1:0], antiblooming_gate_clock};
        end
    end
    assign ia_rise = ia_s[1] && !ia_s[2];
    // a shift edge that finds the fifo full is dropped, not deferred; the register stays put so no packet is lost
    assign sr_rise = sr_s[1] && !sr_s[2] && f_in_ready;
    assign shift_stall = sr_s[1] && !sr_s[2] && !f_in_ready;

    always_comb begin
        next_sreg = sreg;
        next_well = well;
        next_line = line;
        next_lines_left = lines_left;
        next_out_idx = out_idx;
        // an antiblooming edge skips the light update that cycle; darkness keeps the exposed charge for readout
        if (!(ab_s[1] && !ab_s[2]) && light_level != '0) begin
            next_well = light_level;
        end
        if (ia_rise) begin
            // dummy cells keep their charge
            for (int i = DC; i < SC; i++) begin
                next_sreg[i] = '0;
            end
            // one line lands in image cells, dark cells stay empty
            for (int i = DC; i < DC + ffcr_pkg::IMG_PIX; i++) begin
                next_sreg[i] = (lines_left != 8'h00) ? well : '0;
            end
            // last line gone: image area stays empty until the next exposure
            if (lines_left <= 8'h01) begin
                next_well = '0;
            end
            next_lines_left = (lines_left != 8'h00) ? lines_left - 8'h01 : 8'(ffcr_pkg::LINES - 1);
            next_line = 8'(ffcr_pkg::LINES) - lines_left;
            next_out_idx = '0;
        end else if (sr_rise) begin
            for (int i = 0; i < SC - 1; i++) begin
                next_sreg[i] = sreg[i+1];
            end
            next_sreg[SC-1] = '0;
            next_out_idx = (out_idx == 8'(SC - 1)) ? out_idx : out_idx + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < SC; i++) begin
                sreg[i] <= '0;
            end
            well       <= '0;
            line       <= ffcr_pkg::LINE_RST;
            lines_left <= 8'(ffcr_pkg::LINES);
            out_idx    <= '0;
        end else begin
            sreg       <= next_sreg;
            well       <= next_well;
            line       <= next_line;
            lines_left <= next_lines_left;
            out_idx    <= next_out_idx;
        end
    end

    always_comb begin
        pkt.charge = sreg[0];
        pkt.kind   = kind_of(out_idx);
        pkt.line   = line;
    end

    ffcr_fifo #(
        .W ($bits(ffcr_pkg::ffcr_pix_s)),
        .D (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (sr_rise),
        .in_ready  (f_in_ready),
        .in_data   (pkt),
        .out_valid (pix_valid),
        .out_ready (pix_ready),
        .out_data  (pix)
    );

    dummy_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
        ia_rise |=> sreg[0] == $past(sreg[0]))
        else $error("dummy cell cleared by transfer");
    dark_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        ia_rise |=> sreg[SC-1] == '0)
        else $error("dark cell not cleared");
    line_step_a: assert property (@(posedge clk) disable iff (!rst_b)
        ia_rise && lines_left != 8'h00 |=> lines_left == $past(lines_left) - 8'h01)
        else $error("transfer did not move one line");
    line_range_a: assert property (@(posedge clk) disable iff (!rst_b)
        lines_left <= 8'(ffcr_pkg::LINES))
        else $error("line count out of range");
    shift_push_a: assert property (@(posedge clk) disable iff (!rst_b)
        sr_rise && !ia_rise |=> sreg[0] == $past(sreg[1]))
        else $error("shift lost a packet");
    stall_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        shift_stall && !ia_rise |=> out_idx == $past(out_idx))
        else $error("stalled shift advanced");
    image_kind_a: assert property (@(posedge clk) disable iff (!rst_b)
        out_idx == 8'(DC) |-> pkt.kind == ffcr_pkg::FFCR_KIND_IMAGE)
        else $error("first image cell mislabelled");
    dark_kind_a: assert property (@(posedge clk) disable iff (!rst_b)
        out_idx == 8'(SC - 1) |-> pkt.kind == ffcr_pkg::FFCR_KIND_DARK)
        else $error("last cell not dark");

    line_read_c: cover property (@(posedge clk) disable iff (!rst_b) out_idx == 8'(SC - 1));
    stall_c: cover property (@(posedge clk) disable iff (!rst_b) shift_stall);
    frame_c: cover property (@(posedge clk) disable iff (!rst_b) lines_left == 8'h00);
endmodule // ffcr_sensor
